// [rtl/drive_network_coil_map.sv]
// network coil map of the motor drive: command, terminal, status and error coils
//
// How it works
// - coils are single bits, network address 30001+offset.
// - run coil runs motor when source selects 03.
// - direction coil 1 forward, only when source 03.
// - trip coil and fault clear coil are read-write.
// - coils 07h-0Bh mirror input terminals one-five.
// - terminal on when pin or coil on.
// - physical pin overrides the network coil.
// - pin on then off clears the coil.
// - run, direction and ready status coils read-only.
// - flag coils 14h-19h report drive flags.
// - error coils latch until reset.
// - error reset accepted at any time.
// - store coil reads 1 while storing.
// - writing read-only coil returns exception.
`timescale 1ns/1ps
`include "coil_map_regs.svh"
module drive_network_coil_map #(
    parameter int TERM_COUNT = 5
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rstn,
    input  wire logic                      clk_en,
    input  wire logic                      coil_req,
    input  wire coil_map_pkg::coil_req_t   coil_cmd,
    output logic                           coil_ack_q,
    output logic                           coil_rdata_q,
    output logic                           coil_exc_q,
    output logic [7:0]                     coil_exc_code_q,
    input  wire logic [1:0]                run_source_select,
    input  wire logic [1:0]                direction_monitor,
    input  wire coil_map_pkg::drive_status_t drive_status,
    input  wire coil_map_pkg::link_err_t   link_err_event,
    input  wire logic                      err_clear,
    input  wire logic [TERM_COUNT-1:0]     terminal_pin,
    output logic                           run_cmd_q,
    output logic                           forward_dir_cmd_q,
    output logic                           outside_trip_q,
    output logic                           fault_clear_q,
    output logic [TERM_COUNT-1:0]          terminal_on_q,
    output coil_map_pkg::link_err_t        link_err_q
);
    import coil_map_pkg::*;

    localparam int NET_BASE = `COIL_NET_BASE;

    if (TERM_COUNT < 1 || TERM_COUNT > 5) begin : g_bad_terms
        $error("drive_network_coil_map: TERM_COUNT must lie in 1..5");
    end

    if (NET_BASE + int'(`COIL_SUM) > 32'hFFFF) begin : g_bad_base
        $error("drive_network_coil_map: network coil addresses exceed 16 bits");
    end

    logic                  run_coil_q;
    logic                  dir_coil_q;
    logic                  trip_coil_q;
    logic                  fclr_coil_q;
    logic [TERM_COUNT-1:0] term_coil_q;
    logic [TERM_COUNT-1:0] pin_s;
    logic [TERM_COUNT-1:0] pin_prev_q;
    logic [TERM_COUNT-1:0] pin_fall;
    logic                  take;
    logic                  wr_ok;
    logic                  rd_val;
    logic                  err_clr_all;
    logic                  net_src;

    // writable coil decode, shared by write strobe and exception path
    function automatic logic is_rw(input logic [15:0] a);
        is_rw = (a == `COIL_RUN) || (a == `COIL_DIR) || (a == `COIL_TRIP) ||
                (a == `COIL_FCLR) ||
                (a >= `COIL_TERM_FIRST &&
                 a < `COIL_TERM_FIRST + 16'(TERM_COUNT));
    endfunction

    // any coil offset present in the map
    function automatic logic is_mapped(input logic [15:0] a);
        is_mapped = (a <= `COIL_TERM_LAST) ||
                    (a >= `COIL_UNUSED && a <= `COIL_SUM);
    endfunction

    pin_sync #(
        .WIDTH      (TERM_COUNT)
    ) u_pin_sync (
        .clk_sys    (clk_sys),
        .rstn       (rstn),
        .clk_en     (clk_en),
        .pin_async  (terminal_pin),
        .pin_sync_q (pin_s)
    );

    assign take     = clk_en && coil_req;
    assign wr_ok    = take && coil_cmd.wr && is_rw(coil_cmd.addr);
    assign pin_fall = pin_prev_q & ~pin_s;
    assign net_src  = (run_source_select == `RUN_SRC_NETWORK);

    // command coils
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            run_coil_q  <= `COIL_RST;
            dir_coil_q  <= `COIL_RST;
            trip_coil_q <= `COIL_RST;
            fclr_coil_q <= `COIL_RST;
        end else if (wr_ok) begin
            if (coil_cmd.addr == `COIL_RUN) begin
                run_coil_q <= coil_cmd.wdata;
            end
            if (coil_cmd.addr == `COIL_DIR) begin
                dir_coil_q <= coil_cmd.wdata;
            end
            if (coil_cmd.addr == `COIL_TRIP) begin
                trip_coil_q <= coil_cmd.wdata;
            end
            if (coil_cmd.addr == `COIL_FCLR) begin
                fclr_coil_q <= coil_cmd.wdata;
            end
        end
    end

    // pin history for the on-then-off clear
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pin_prev_q <= '0;
        end else if (clk_en) begin
            pin_prev_q <= pin_s;
        end
    end

    // terminal coils; a pin release beats a same-cycle network write
    for (genvar i = 0; i < TERM_COUNT; i++) begin : g_term
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                term_coil_q[i] <= `COIL_RST;
            end else if (clk_en) begin
                if (pin_fall[i]) begin
                    term_coil_q[i] <= 1'b0;
                end else if (wr_ok && coil_cmd.addr == `COIL_TERM_FIRST + 16'(i)) begin
                    term_coil_q[i] <= coil_cmd.wdata;
                end
            end
        end
    end

    // drive-facing command outputs
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            run_cmd_q         <= 1'b0;
            forward_dir_cmd_q <= 1'b0;
            outside_trip_q    <= 1'b0;
            fault_clear_q     <= 1'b0;
            terminal_on_q     <= '0;
        end else if (clk_en) begin
            run_cmd_q         <= net_src && run_coil_q;
            forward_dir_cmd_q <= net_src && dir_coil_q;
            outside_trip_q    <= trip_coil_q;
            fault_clear_q     <= fclr_coil_q;
            terminal_on_q     <= pin_s | term_coil_q;
        end
    end

    // latched transmission errors; a new error wins over a clear
    assign err_clr_all = err_clear || fclr_coil_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            link_err_q <= '0;
        end else if (clk_en) begin
            link_err_q <= link_err_event | (err_clr_all ? '0 : link_err_q);
        end
    end

    // live read value of the addressed coil
    always_comb begin
        rd_val = 1'b0;
        unique case (coil_cmd.addr)
            `COIL_RUN:          rd_val = run_coil_q;
            `COIL_DIR:          rd_val = dir_coil_q;
            `COIL_TRIP:         rd_val = trip_coil_q;
            `COIL_FCLR:         rd_val = fclr_coil_q;
            `COIL_RUNNING:      rd_val = (direction_monitor != `DIRMON_STOP);
            `COIL_DIRSTATE:     rd_val = (direction_monitor == `DIRMON_REVERSE);
            `COIL_READY:        rd_val = drive_status.ready;
            `COIL_ALARM:        rd_val = drive_status.fault_alarm;
            `COIL_DEVIATION:    rd_val = drive_status.loop_deviation;
            `COIL_OVERLOAD:     rd_val = drive_status.overload;
            `COIL_SPEED_ABOVE:  rd_val = drive_status.speed_above;
            `COIL_SPEED_STEADY: rd_val = drive_status.speed_steady;
            `COIL_RUNFLAG:      rd_val = drive_status.running_flag;
            `COIL_STORE:        rd_val = drive_status.store_busy;
            `COIL_CRC:          rd_val = link_err_q.crc;
            `COIL_OVERRUN:      rd_val = link_err_q.overrun;
            `COIL_FRAMING:      rd_val = link_err_q.framing;
            `COIL_PARITY:       rd_val = link_err_q.parity;
            `COIL_SUM:          rd_val = link_err_q.sum;
            default: begin
                if (coil_cmd.addr >= `COIL_TERM_FIRST &&
                    coil_cmd.addr < `COIL_TERM_FIRST + 16'(TERM_COUNT)) begin
                    rd_val = term_coil_q[coil_cmd.addr[2:0] - 3'h7];
                end
            end
        endcase
    end

    // answer one cycle after the request is taken
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            coil_ack_q      <= 1'b0;
            coil_rdata_q    <= 1'b0;
            coil_exc_q      <= 1'b0;
            coil_exc_code_q <= 8'h00;
        end else if (clk_en) begin
            coil_ack_q      <= coil_req;
            coil_rdata_q    <= 1'b0;
            coil_exc_q      <= 1'b0;
            coil_exc_code_q <= 8'h00;
            if (coil_req) begin
                if (!is_mapped(coil_cmd.addr)) begin
                    coil_exc_q      <= 1'b1;
                    coil_exc_code_q <= `EXC_NO_ADDR;
                end else if (coil_cmd.wr && !is_rw(coil_cmd.addr)) begin
                    coil_exc_q      <= 1'b1;
                    coil_exc_code_q <= `EXC_NOT_AVAIL;
                end else if (!coil_cmd.wr) begin
                    coil_rdata_q    <= rd_val;
                end
            end
        end
    end

    // checks

    AST_RUN_GATED: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && run_cmd_q |-> net_src || $past(net_src) || !$past(clk_en))
        else $error("run command active without network run source");

    AST_RUN_FOLLOWS: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && net_src && $stable(run_coil_q) |=> run_cmd_q == $past(run_coil_q))
        else $error("run command does not follow run coil");

    AST_DIR_GATED: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && !net_src |=> !forward_dir_cmd_q)
        else $error("direction command active without network run source");

    AST_TRIP_WRITE: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_ok && coil_cmd.addr == `COIL_TRIP ##1 clk_en [*2]
        |-> outside_trip_q == $past(coil_cmd.wdata, 2))
        else $error("trip output does not take written coil value");

    AST_TERM_OR: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && pin_s[0] |=> terminal_on_q[0])
        else $error("terminal not on while its pin is on");

    AST_PIN_CLEAR: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && pin_fall[0] |=> !term_coil_q[0])
        else $error("pin release did not clear terminal coil");

    AST_ERR_LATCH: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && link_err_event.crc |=> link_err_q.crc [*1] ##0 !clk_en || link_err_q.crc)
        else $error("crc error not latched");

    AST_ERR_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
        link_err_q.parity && !err_clr_all |=> link_err_q.parity)
        else $error("parity error lost without a clear");

    AST_ERR_CLEAR: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && err_clear && link_err_event == '0 |=> link_err_q == '0)
        else $error("error clear not accepted");

    AST_RO_EXC: assert property (@(posedge clk_sys) disable iff (!rstn)
        take && coil_cmd.wr && coil_cmd.addr == `COIL_READY
        |=> coil_ack_q && coil_exc_q && coil_exc_code_q == `EXC_NOT_AVAIL)
        else $error("write to read-only coil not refused");

    AST_RSVD_ZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
        take && !coil_cmd.wr && coil_cmd.addr == `COIL_RSVD_B |=> !coil_rdata_q)
        else $error("reserved coil read as one");

    AST_STORE_LIVE: assert property (@(posedge clk_sys) disable iff (!rstn)
        take && !coil_cmd.wr && coil_cmd.addr == `COIL_STORE
        |=> coil_rdata_q == $past(drive_status.store_busy))
        else $error("store coil does not show store progress");

    AST_RUN_STATUS: assert property (@(posedge clk_sys) disable iff (!rstn)
        take && !coil_cmd.wr && coil_cmd.addr == `COIL_RUNNING
        |=> coil_rdata_q == ($past(direction_monitor) != `DIRMON_STOP))
        else $error("run status does not match direction monitor");

    AST_DIR_STATUS: assert property (@(posedge clk_sys) disable iff (!rstn)
        take && !coil_cmd.wr && coil_cmd.addr == `COIL_DIRSTATE
        |=> coil_rdata_q == ($past(direction_monitor) == `DIRMON_REVERSE))
        else $error("direction status does not match direction monitor");

    AST_FLAG_LIVE: assert property (@(posedge clk_sys) disable iff (!rstn)
        take && !coil_cmd.wr && coil_cmd.addr == `COIL_ALARM
        |=> coil_rdata_q == $past(drive_status.fault_alarm))
        else $error("alarm coil does not show the alarm flag");

    AST_TERM_WRITE: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_ok && coil_cmd.addr == `COIL_TERM_FIRST && !pin_fall[0]
        |=> term_coil_q[0] == $past(coil_cmd.wdata))
        else $error("terminal coil does not take the written value");

    AST_TERM_OFF: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && pin_s == '0 && term_coil_q == '0 |=> terminal_on_q == '0)
        else $error("terminal on while pin and coil are off");

    AST_PIN_WINS: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && pin_s != '0 |=> (terminal_on_q & $past(pin_s)) == $past(pin_s))
        else $error("terminal off while its pin is on");

    AST_ERR_FCLR: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && fclr_coil_q && link_err_event == '0 |=> link_err_q == '0)
        else $error("fault clear coil does not clear the error latches");

    AST_ERR_FREEZE: assert property (@(posedge clk_sys) disable iff (!rstn)
        !clk_en |=> $stable(link_err_q) && $stable(terminal_on_q))
        else $error("state changed while clock enable low");

    AST_NO_ADDR: assert property (@(posedge clk_sys) disable iff (!rstn)
        take && coil_cmd.addr > `COIL_SUM
        |=> coil_ack_q && coil_exc_q && coil_exc_code_q == `EXC_NO_ADDR)
        else $error("access beyond the coil map not refused");

    AST_RSVD_KEEP: assert property (@(posedge clk_sys) disable iff (!rstn)
        take && coil_cmd.wr && !is_rw(coil_cmd.addr)
        |=> $stable(run_coil_q) && $stable(dir_coil_q) && $stable(trip_coil_q) &&
            $stable(fclr_coil_q))
        else $error("write to a non-writable coil changed a command coil");

    AST_IDLE_QUIET: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && !coil_req |=> !coil_ack_q && !coil_exc_q && !coil_rdata_q)
        else $error("answer given without a request");

    AST_FCLR_OUT: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en |=> fault_clear_q == $past(fclr_coil_q))
        else $error("fault clear output does not follow its coil");

    AST_DIR_FOLLOWS: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && net_src |=> forward_dir_cmd_q == $past(dir_coil_q))
        else $error("direction command does not follow direction coil");

endmodule

// [rtl/coil_map_regs.svh]
// coil offsets, exception codes and reset values of the network coil map
`ifndef COIL_MAP_REGS_SVH
`define COIL_MAP_REGS_SVH

`define COIL_NET_BASE       30001
`define COIL_RSVD_A         16'h0000
`define COIL_RUN            16'h0001
`define COIL_DIR            16'h0002
`define COIL_TRIP           16'h0003
`define COIL_FCLR           16'h0004
`define COIL_RSVD_B         16'h0005
`define COIL_RSVD_C         16'h0006
`define COIL_TERM_FIRST     16'h0007
`define COIL_TERM_LAST      16'h000B
`define COIL_UNUSED         16'h000D
`define COIL_RUNNING        16'h000E
`define COIL_DIRSTATE       16'h000F
`define COIL_READY          16'h0010
`define COIL_RSVD_D         16'h0011
`define COIL_RSVD_E         16'h0012
`define COIL_RSVD_F         16'h0013
`define COIL_ALARM          16'h0014
`define COIL_DEVIATION      16'h0015
`define COIL_OVERLOAD       16'h0016
`define COIL_SPEED_ABOVE    16'h0017
`define COIL_SPEED_STEADY   16'h0018
`define COIL_RUNFLAG        16'h0019
`define COIL_STORE          16'h001A
`define COIL_CRC            16'h001B
`define COIL_OVERRUN        16'h001C
`define COIL_FRAMING        16'h001D
`define COIL_PARITY         16'h001E
`define COIL_SUM            16'h001F

`define RUN_SRC_NETWORK     2'h3
`define DIRMON_STOP         2'h0
`define DIRMON_REVERSE      2'h2
`define EXC_NO_ADDR         8'h02
`define EXC_NOT_AVAIL       8'h22
`define COIL_RST            1'b0

`endif

// [rtl/coil_map_pkg.sv]
// types shared by the network coil map
package coil_map_pkg;

    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic wdata;
    } coil_req_t;

    typedef struct packed {
        logic ready;
        logic fault_alarm;
        logic loop_deviation;
        logic overload;
        logic speed_above;
        logic speed_steady;
        logic running_flag;
        logic store_busy;
    } drive_status_t;

    typedef struct packed {
        logic crc;
        logic overrun;
        logic framing;
        logic parity;
        logic sum;
    } link_err_t;

endpackage

// [rtl/pin_sync.sv]
// two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 5
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] pin_async,
    output logic      [WIDTH-1:0] pin_sync_q
);

    logic [WIDTH-1:0] meta_q;

    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta_q     <= '0;
            pin_sync_q <= '0;
        end else if (clk_en) begin
            meta_q     <= pin_async;
            pin_sync_q <= meta_q;
        end
    end

endmodule

// [bench/coil_master.sv]
// network master model: one single-coil request at a time
`timescale 1ns/1ps
module coil_master (
    input  wire logic               clk_sys,
    output logic                    coil_req,
    output coil_map_pkg::coil_req_t coil_cmd,
    input  wire logic               coil_ack_q,
    input  wire logic               coil_rdata_q,
    input  wire logic               coil_exc_q,
    input  wire logic [7:0]         coil_exc_code_q
);
    import coil_map_pkg::*;
    initial begin
        coil_req = 1'b0;
        coil_cmd = '0;
    end
    // offset only; the wire address is base plus offset
    task automatic access(input logic wr, input logic [15:0] a, input logic wd,
                          output logic rd, output logic ex, output logic [7:0] cd);
        int n;
        n = 0;
        @(negedge clk_sys);
        coil_req = 1'b1;
        coil_cmd = '{wr: wr, addr: a, wdata: wd};
        @(negedge clk_sys);
        coil_req = 1'b0;
        coil_cmd = '{wr: 1'b0, addr: ~a, wdata: ~wd};
        while (coil_ack_q !== 1'b1 && n < 4) begin
            @(negedge clk_sys);
            n++;
        end
        rd = coil_rdata_q;
        ex = (n < 4) ? coil_exc_q : 1'bx;
        cd = coil_exc_code_q;
    endtask
endmodule

// [bench/drive_network_coil_map_tb_top.sv]
// testbench of the network coil map
`timescale 1ns/1ps
module drive_network_coil_map_tb_top;
    import coil_map_pkg::*;
    logic          clk_sys;
    logic          rstn;
    logic          clk_en;
    logic          coil_req;
    coil_req_t     coil_cmd;
    logic          ack;
    logic          rdata;
    logic          exc;
    logic [7:0]    code;
    logic [1:0]    run_source_select;
    logic [1:0]    direction_monitor;
    drive_status_t drive_status;
    link_err_t     link_err_event;
    logic          err_clear;
    logic [4:0]    terminal_pin;
    logic          run_cmd_q;
    logic          forward_dir_cmd_q;
    logic          outside_trip_q;
    logic          fault_clear_q;
    logic [4:0]    terminal_on_q;
    link_err_t     link_err_q;
    int            err_count = 0;
    int            total_checks = 0;
    logic [15:0]   rsvd [7] = '{16'h0000, 16'h0005, 16'h0006, 16'h000D,
                               16'h0011, 16'h0012, 16'h0013};

    drive_network_coil_map #(.TERM_COUNT(5)) uut (
        .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .coil_req(coil_req),
        .coil_cmd(coil_cmd), .coil_ack_q(ack), .coil_rdata_q(rdata),
        .coil_exc_q(exc), .coil_exc_code_q(code),
        .run_source_select(run_source_select), .direction_monitor(direction_monitor),
        .drive_status(drive_status), .link_err_event(link_err_event),
        .err_clear(err_clear), .terminal_pin(terminal_pin), .run_cmd_q(run_cmd_q),
        .forward_dir_cmd_q(forward_dir_cmd_q), .outside_trip_q(outside_trip_q),
        .fault_clear_q(fault_clear_q), .terminal_on_q(terminal_on_q),
        .link_err_q(link_err_q));

    coil_master mst (
        .clk_sys(clk_sys), .coil_req(coil_req), .coil_cmd(coil_cmd),
        .coil_ack_q(ack), .coil_rdata_q(rdata), .coil_exc_q(exc),
        .coil_exc_code_q(code));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic report_and_stop();
        if (err_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // one access with expected read bit and exception code (00 = none)
    task automatic acc(input logic wr, input logic [15:0] a, input logic wd,
                       input logic erd, input logic [7:0] ecd);
        logic       rd;
        logic       ex;
        logic [7:0] cd;
        mst.access(wr, a, wd, rd, ex, cd);
        chk("rdata", 16'(erd), 16'(rd));
        chk("exc", 16'(ecd != 8'h00), 16'(ex));
        chk("code", 16'(ecd), 16'(cd));
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        report_and_stop();
    end

    initial begin
        rstn = 1'b0;
        clk_en = 1'b1;
        run_source_select = 2'h3;
        direction_monitor = 2'h0;
        drive_status = '0;
        link_err_event = '0;
        err_clear = 1'b0;
        terminal_pin = '0;
        step(6);
        chk("outs", 16'h0000, {7'h00, run_cmd_q, forward_dir_cmd_q, outside_trip_q,
            fault_clear_q, terminal_on_q});
        rstn = 1'b1;
        acc(1'b1, 16'h0001, 1'b1, 1'b0, 8'h00);
        acc(1'b1, 16'h0002, 1'b1, 1'b0, 8'h00);
        step(2);
        chk("run_cmd", 16'h0001, 16'(run_cmd_q));
        chk("fwd_cmd", 16'h0001, 16'(forward_dir_cmd_q));
        acc(1'b0, 16'h0001, 1'b0, 1'b1, 8'h00);
        run_source_select = 2'h0;
        step(2);
        chk("run_cmd", 16'h0000, 16'(run_cmd_q));
        chk("fwd_cmd", 16'h0000, 16'(forward_dir_cmd_q));
        acc(1'b1, 16'h0003, 1'b1, 1'b0, 8'h00);
        acc(1'b1, 16'h0004, 1'b1, 1'b0, 8'h00);
        step(2);
        chk("trip", 16'h0003, {14'h0, outside_trip_q, fault_clear_q});
        acc(1'b1, 16'h0004, 1'b0, 1'b0, 8'h00);
        acc(1'b0, 16'h0003, 1'b0, 1'b1, 8'h00);
        for (int i = 0; i < 5; i++) begin
            acc(1'b1, 16'h0007 + 16'(i), 1'b1, 1'b0, 8'h00);
            step(2);
            chk("term_on", 16'(1 << i), 16'(terminal_on_q));
            terminal_pin[i] = 1'b1;
            step(5);
            chk("term_on", 16'(1 << i), 16'(terminal_on_q));
            terminal_pin[i] = 1'b0;
            step(5);
            acc(1'b0, 16'h0007 + 16'(i), 1'b0, 1'b0, 8'h00);
            chk("term_on", 16'h0000, 16'(terminal_on_q));
        end
        acc(1'b0, 16'h000E, 1'b0, 1'b0, 8'h00);
        acc(1'b0, 16'h000F, 1'b0, 1'b0, 8'h00);
        direction_monitor = 2'h2;
        drive_status = 8'h80;
        acc(1'b0, 16'h000E, 1'b0, 1'b1, 8'h00);
        acc(1'b0, 16'h000F, 1'b0, 1'b1, 8'h00);
        acc(1'b0, 16'h0010, 1'b0, 1'b1, 8'h00);
        direction_monitor = 2'h1;
        drive_status = 8'h7F;
        acc(1'b0, 16'h000E, 1'b0, 1'b1, 8'h00);
        acc(1'b0, 16'h000F, 1'b0, 1'b0, 8'h00);
        acc(1'b0, 16'h0010, 1'b0, 1'b0, 8'h00);
        for (int i = 0; i < 7; i++) begin
            drive_status = 8'h40 >> i;
            acc(1'b0, 16'h0014 + 16'(i), 1'b0, 1'b1, 8'h00);
            drive_status = ~(8'h40 >> i);
            acc(1'b0, 16'h0014 + 16'(i), 1'b0, 1'b0, 8'h00);
        end
        // motor reported running while errors are latched and cleared
        for (int i = 0; i < 5; i++) begin
            link_err_event = 5'h10 >> i;
            step(1);
            link_err_event = '0;
            step(3);
            chk("err_q", 16'(5'h10 >> i), 16'(link_err_q));
            acc(1'b0, 16'h001B + 16'(i), 1'b0, 1'b1, 8'h00);
            err_clear = 1'b1;
            step(1);
            err_clear = 1'b0;
            step(1);
            chk("err_q", 16'h0000, 16'(link_err_q));
        end
        acc(1'b1, 16'h000E, 1'b1, 1'b0, 8'h22);
        acc(1'b1, 16'h001B, 1'b1, 1'b0, 8'h22);
        acc(1'b0, 16'h001B, 1'b0, 1'b0, 8'h00);
        foreach (rsvd[k]) begin
            acc(1'b1, rsvd[k], 1'b1, 1'b0, 8'h22);
            acc(1'b0, rsvd[k], 1'b0, 1'b0, 8'h00);
        end
        acc(1'b0, 16'h000C, 1'b0, 1'b0, 8'h02);
        acc(1'b1, 16'h0020, 1'b1, 1'b0, 8'h02);
        // enable low freezes all state; the held inputs are taken afterwards
        clk_en = 1'b0;
        link_err_event = 5'h01;
        terminal_pin = 5'h01;
        step(4);
        chk("frozen", 16'h0000, {11'h000, link_err_q});
        chk("frozen", 16'h0000, 16'(terminal_on_q));
        clk_en = 1'b1;
        step(1);
        link_err_event = '0;
        step(4);
        chk("err_q", 16'h0001, 16'(link_err_q));
        chk("term_on", 16'h0001, 16'(terminal_on_q));
        // fault clear coil held high clears the error latches too
        acc(1'b1, 16'h0004, 1'b1, 1'b0, 8'h00);
        step(1);
        chk("err_q", 16'h0000, 16'(link_err_q));
        acc(1'b1, 16'h0004, 1'b0, 1'b0, 8'h00);
        // reset in mid-run clears coils and outputs
        acc(1'b1, 16'h0003, 1'b1, 1'b0, 8'h00);
        step(2);
        rstn = 1'b0;
        step(2);
        chk("outs", 16'h0000, {2'h0, link_err_q, run_cmd_q, forward_dir_cmd_q,
            outside_trip_q, fault_clear_q, terminal_on_q});
        rstn = 1'b1;
        acc(1'b0, 16'h0003, 1'b0, 1'b0, 8'h00);
        report_and_stop();
    end
endmodule
